/* File: hw/pmec_defines.svh */
// Offsets, field positions and reset values of the maintenance error/halt block
`ifndef PMEC_DEFINES_SVH
`define PMEC_DEFINES_SVH

// Register byte offsets
`define PMEC_OFF_CSR 4'h0
`define PMEC_OFF_ISR 4'h4
`define PMEC_OFF_IMR 4'h8
`define PMEC_OFF_CTL 4'hc

// Control/status fields
`define PMEC_FLAG_LSB 8
`define PMEC_FLAG_MSB 15
`define PMEC_HALT_BIT 7
`define PMEC_INIT_BIT 0
`define PMEC_ISR_MTE_BIT 8

// Reset values
`define PMEC_HALT_RST 1'b0
`define PMEC_FLAG_RST 1'b0
`define PMEC_IMR_RST 9'h000

`endif

/* File: hw/pmec_pkg.sv */
// Types shared by the maintenance error/halt block
package pmec_pkg;

  // Error events, msb lines up with control/status bit 15
  typedef struct packed {
    logic bus_par;
    logic store_par;
    logic ib_par;
    logic xbuf_par;
    logic lp_par;
    logic map_err;
    logic if_par;
    logic timeout;
  } pmec_err_t;

  // Qualifiers for the error events
  typedef struct packed {
    logic own_master;
    logic store_host_read;
    logic ib_unsol_write;
    logic ib_local_read;
    logic link_unloading;
    logic map_xact;
    logic if_read;
  } pmec_qual_t;

  // Port state, one-hot
  typedef enum logic [1:0] {
    PMEC_UNINIT = 2'b01,
    PMEC_ACTIVE = 2'b10
  } pmec_state_t;

endpackage : pmec_pkg

/* File: hw/pmec_sticky.sv */
// Sticky flag: set wins over clear
`timescale 1ns/10ps
`default_nettype none

module pmec_sticky (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic set,
  input wire logic clr,
  output logic q
);

  // Hold until cleared; a set in the clear cycle survives
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end

endmodule : pmec_sticky

`default_nettype wire

/* File: hw/pmec_top.sv */
// Port maintenance error flags, halt control and register slave
//
// Behaviour
// - Backplane parity error in own master transaction sets bit 15 and maint error
// - Store parity error while microcode runs sets bit 14 and maint error
// - No store parity flag on host store reads while uninitialized
// - Internal bus parity on unsolicited writes or local reads sets bit 13
// - Transmit buffer parity while the link unloads sets bit 12, aborts transmission, sets maint error
// - Link-port bus parity sets bit 11; microcode then raises maint error
// - Map transaction error code sets bit 10 and maint error
// - Interface bus read parity sets bit 9 and maint error
// - Bus timeout input sets bit 8 for microcode recovery
// - Halt bit 7 is read/write and stops the microsequencer
// - Clearing halt resumes the sequencer unless power-up is running or maint error is set
// - Bus stop command sets halt and blocks backplane traffic
// - Maint error makes port uninitialized, halts microcode, interrupts, keeps flags
`timescale 1ns/10ps
`default_nettype none
`include "pmec_defines.svh"

module pmec_top
  import pmec_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire pmec_err_t err_in,
  input wire pmec_qual_t qual_in,
  input wire logic ucode_maint_set,
  input wire logic bus_stop_cmd,
  input wire logic power_up_busy,
  input wire logic port_init_in,
  output logic seq_halt,
  output logic backplane_inhibit,
  output logic xmit_abort,
  output logic port_maint_error,
  output logic port_uninit,
  output logic irq
);

  // ****************************************
  // Bus slave
  // ****************************************
  logic ack_q;
  logic req;
  logic wr_en;
  logic [31:0] rd_d;
  logic [31:0] avs_readdata_q;

  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign wr_en = avs_write & ack_q; // Write lands at the edge waitrequest is low
  assign avs_readdata = avs_readdata_q;

  // One wait cycle per access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ****************************************
  // Error flags
  // ****************************************
  logic [7:0] ev;
  logic [7:0] flags;
  logic init_pulse_q;
  pmec_state_t state_q;
  logic halt_q;
  logic maint_err_q;
  logic ucode_running;

  assign ucode_running = ~seq_halt;

  // Qualified error events
  always_comb begin
    ev = 8'h00;
    ev[7] = err_in.bus_par & qual_in.own_master;
    ev[6] = err_in.store_par & ucode_running
            & ~(qual_in.store_host_read & (state_q == PMEC_UNINIT));
    ev[5] = err_in.ib_par & (qual_in.ib_unsol_write | qual_in.ib_local_read);
    ev[4] = err_in.xbuf_par & qual_in.link_unloading;
    ev[3] = err_in.lp_par;
    ev[2] = err_in.map_err & qual_in.map_xact;
    ev[1] = err_in.if_par & qual_in.if_read;
    ev[0] = err_in.timeout;
  end

  // Flags ignore writes, clear only on initialize
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      pmec_sticky u_flag (
        .clk(clk),
        .reset_n(reset_n),
        .set(ev[gi]),
        .clr(init_pulse_q),
        .q(flags[gi])
      );
    end
  endgenerate

  // Transmission abort on buffer parity
  assign xmit_abort = ev[4];

  // ****************************************
  // Maintenance error and port state
  // ****************************************
  logic mte_set;

  // Hardware error events except link-port parity and timeout, and the microcode request, raise it
  assign mte_set = ev[7] | ev[6] | ev[5] | ev[4] | ev[2] | ev[1]
                   | ucode_maint_set;

  // Maintenance error, kept until initialize
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      maint_err_q <= 1'b0;
    end else if (mte_set) begin
      maint_err_q <= 1'b1;
    end else if (init_pulse_q) begin
      maint_err_q <= 1'b0;
    end
  end

  // Port state: maint error forces uninitialized
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= PMEC_UNINIT;
    end else begin
      case (state_q)
        PMEC_UNINIT: begin
          if (port_init_in && !mte_set && !maint_err_q) begin
            state_q <= PMEC_ACTIVE;
          end
        end
        PMEC_ACTIVE: begin
          if (mte_set) begin
            state_q <= PMEC_UNINIT;
          end
        end
        default: begin
          state_q <= PMEC_UNINIT;
        end
      endcase
    end
  end

  assign port_uninit = (state_q == PMEC_UNINIT);
  assign port_maint_error = maint_err_q;

  // ****************************************
  // Halt control
  // ****************************************
  logic stopped_q;
  logic halt_wr;

  assign halt_wr = wr_en && (avs_address == `PMEC_OFF_CSR) && avs_byteenable[0];

  // Halt bit: stop command sets it, software writes it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      halt_q <= `PMEC_HALT_RST;
    end else if (bus_stop_cmd) begin
      halt_q <= 1'b1;
    end else if (halt_wr) begin
      halt_q <= avs_writedata[`PMEC_HALT_BIT];
    end
  end

  // Stop command memory, cleared by initialize
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stopped_q <= 1'b0;
    end else if (bus_stop_cmd) begin
      stopped_q <= 1'b1;
    end else if (init_pulse_q) begin
      stopped_q <= 1'b0;
    end
  end

  // Sequencer runs only with halt clear, no power-up, no maint error
  assign seq_halt = halt_q | power_up_busy | maint_err_q;
  assign backplane_inhibit = halt_q & stopped_q;

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  logic [8:0] isr_set;
  logic [8:0] isr_clr;
  logic [8:0] isr;
  logic [8:0] imr_q;
  logic isr_wr;

  assign isr_wr = wr_en && (avs_address == `PMEC_OFF_ISR);
  assign isr_set = {mte_set, ev};
  assign isr_clr = isr_wr ? (avs_writedata[8:0] & {avs_byteenable[1], {8{avs_byteenable[0]}}})
                          : 9'h000;

  generate
    for (gi = 0; gi < 9; gi++) begin : g_isr
      pmec_sticky u_isr (
        .clk(clk),
        .reset_n(reset_n),
        .set(isr_set[gi]),
        .clr(isr_clr[gi]),
        .q(isr[gi])
      );
    end
  endgenerate

  // Mask register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      imr_q <= `PMEC_IMR_RST;
    end else if (wr_en && (avs_address == `PMEC_OFF_IMR)) begin
      if (avs_byteenable[0]) begin
        imr_q[7:0] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        imr_q[8] <= avs_writedata[8];
      end
    end
  end

  assign irq = |(isr & imr_q);

  // Initialize pulse from control write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      init_pulse_q <= 1'b0;
    end else begin
      init_pulse_q <= wr_en && (avs_address == `PMEC_OFF_CTL) && avs_byteenable[0]
                      && avs_writedata[`PMEC_INIT_BIT];
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    rd_d = 32'h0000_0000;
    case (avs_address)
      `PMEC_OFF_CSR: begin
        rd_d[`PMEC_FLAG_MSB:`PMEC_FLAG_LSB] = flags;
        rd_d[`PMEC_HALT_BIT] = halt_q;
      end
      `PMEC_OFF_ISR: rd_d[8:0] = isr;
      `PMEC_OFF_IMR: rd_d[8:0] = imr_q;
      `PMEC_OFF_CTL: rd_d[1] = port_uninit;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata_q <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      avs_readdata_q <= rd_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_xbuf_err;
    err_in.xbuf_par && qual_in.link_unloading;
  endsequence

  sequence s_xbuf_done;
    flags[4] && maint_err_q && port_uninit;
  endsequence

  a_bus_par_set: assert property (
    err_in.bus_par && qual_in.own_master |=> flags[7] && maint_err_q)
    else $error("backplane parity flag not set");
  a_store_par_set: assert property (
    err_in.store_par && !seq_halt && !(qual_in.store_host_read && port_uninit)
    |=> flags[6] && maint_err_q)
    else $error("store parity flag not set");
  a_store_inhibit: assert property (
    err_in.store_par && qual_in.store_host_read && port_uninit && !flags[6]
    |=> !flags[6])
    else $error("store parity set on host read");
  a_ib_par_set: assert property (
    err_in.ib_par && (qual_in.ib_unsol_write || qual_in.ib_local_read)
    |=> flags[5] && maint_err_q)
    else $error("internal bus parity flag not set");
  a_xbuf_abort: assert property (
    s_xbuf_err |-> xmit_abort ##1 s_xbuf_done)
    else $error("transmit parity not handled");
  a_lp_par_set: assert property (
    err_in.lp_par |=> flags[3])
    else $error("link-port parity flag not set");
  a_lp_mte: assert property (
    ucode_maint_set |=> maint_err_q)
    else $error("microcode maint error lost");
  a_map_err_set: assert property (
    err_in.map_err && qual_in.map_xact |=> flags[2] && maint_err_q)
    else $error("map error flag not set");
  a_if_par_set: assert property (
    err_in.if_par && qual_in.if_read |=> flags[1] && maint_err_q)
    else $error("interface parity flag not set");
  a_timeout_set: assert property (
    err_in.timeout |=> flags[0] && isr[0])
    else $error("timeout flag not set");
  a_halt_stops: assert property (
    halt_wr && avs_writedata[`PMEC_HALT_BIT] && !bus_stop_cmd |=> halt_q && seq_halt)
    else $error("halt did not stop sequencer");
  a_halt_resume: assert property (
    $fell(halt_q) && !power_up_busy && !maint_err_q |-> !seq_halt)
    else $error("sequencer did not resume");
  a_stop_halt: assert property (
    bus_stop_cmd |=> halt_q && backplane_inhibit)
    else $error("stop command did not halt");
  a_mte_uninit: assert property (
    $rose(maint_err_q) |-> port_uninit && seq_halt && isr[8])
    else $error("maint error effects missing");
  a_flags_hold: assert property (
    !$past(init_pulse_q) |-> ($past(flags) & ~flags) == 8'h00)
    else $error("error flag dropped without init");

endmodule : pmec_top

`default_nettype wire

/* File: verification/pmec_evt_model.sv */
// Behavioural model of the port's internal buses raising error events
`timescale 1ns/10ps
`default_nettype none

module pmec_evt_model
  import pmec_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire pmec_err_t ev,
  input wire pmec_qual_t qv,
  output var pmec_err_t err_in,
  output var pmec_qual_t qual_in
);
  // One-cycle event pulse; idle qualifiers show the inverse of the last value
  always_ff @(posedge clk) begin
    err_in <= go ? ev : '0;
    qual_in <= go ? qv : ~qv;
  end
endmodule : pmec_evt_model

`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the maintenance error and halt block
`timescale 1ns/10ps
`default_nettype none
`include "pmec_defines.svh"

module testbench
  import pmec_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_req;
  pmec_err_t err_in;
  pmec_qual_t qual_in;
  pmec_err_t ev = '0;
  pmec_qual_t qv = '0;
  logic go = 1'b0;
  logic ucode_set = 1'b0;
  logic stop = 1'b0;
  logic pwr = 1'b0;
  logic pinit = 1'b0;
  logic seq_halt, bp_inh, xabort, maint, uninit, irq;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] exp_q[$];

  pmec_top pmec_top_inst (
    .clk(clk), .reset_n(reset_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .err_in(err_in), .qual_in(qual_in),
    .ucode_maint_set(ucode_set), .bus_stop_cmd(stop), .power_up_busy(pwr),
    .port_init_in(pinit), .seq_halt(seq_halt), .backplane_inhibit(bp_inh),
    .xmit_abort(xabort), .port_maint_error(maint), .port_uninit(uninit), .irq(irq)
  );

  pmec_evt_model pmec_evt_model_inst (
    .clk(clk), .go(go), .ev(ev), .qv(qv), .err_in(err_in), .qual_in(qual_in)
  );

  // Clock
  always #50 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Read monitor takes the oldest expected word when data is taken
  always @(posedge clk) begin
    if (rd === 1'b1 && wait_req === 1'b0 && exp_q.size() > 0) begin
      check(rdata, exp_q.pop_front());
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    if (n >= 50) fail_count++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic rdx(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rdx

  // One error event through the model
  task automatic fire(input pmec_err_t e, input pmec_qual_t q);
    @(posedge clk);
    ev <= e;
    qv <= q;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    check(xabort, 32'(e.xbuf_par & q.link_unloading));
    @(posedge clk);
  endtask : fire

  // One-cycle strobe: 0 port init, 1 microcode maint error, else stop command
  task automatic pulse(input int sel);
    @(posedge clk);
    case (sel)
      0: pinit <= 1'b1;
      1: ucode_set <= 1'b1;
      default: stop <= 1'b1;
    endcase
    @(posedge clk);
    pinit <= 1'b0;
    ucode_set <= 1'b0;
    stop <= 1'b0;
    @(posedge clk);
  endtask : pulse

  // Initialize, clear status, bring port active
  task automatic init_port();
    bus(1'b1, `PMEC_OFF_CTL, 32'h1);
    bus(1'b1, `PMEC_OFF_ISR, 32'h1ff);
    pulse(0);
  endtask : init_port

  // ****************
  // Main sequence
  // ****************
  initial begin
    pmec_qual_t qt [8];
    pmec_err_t e;
    logic m;
    void'($urandom(32'h143b));
    qt = '{7'h00, 7'h01, 7'h02, 7'h00, 7'h04, 7'h10, 7'h00, 7'h40};
    if ($urandom_range(1) == 1) qt[5] = 7'h08;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rdx(`PMEC_OFF_CSR, 32'h0);
    rdx(`PMEC_OFF_CTL, 32'h2);
    bus(1'b1, `PMEC_OFF_IMR, 32'h1ff);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      init_port();
      e = 8'h01 << i;
      m = (i != 0 && i != 3);
      if (qt[i] != 7'h00) begin
        fire(e, '0);
        rdx(`PMEC_OFF_CSR, 32'h0);
      end
      fire(e, qt[i]);
      rdx(`PMEC_OFF_CSR, 32'({e, 8'h00}));
      rdx(`PMEC_OFF_ISR, 32'({m, e}));
      check(maint, m);
      check(uninit, m);
      check(seq_halt, m);
      check(irq, 1'b1);
      if (i == 3) begin
        pulse(1);
        check(maint, 1'b1);
      end
    end
    $display("event test done");
    bus(1'b1, `PMEC_OFF_CSR, 32'h0000ff00);
    rdx(`PMEC_OFF_CSR, 32'h8000);
    bus(1'b1, 4'h2, $urandom);
    rdx(4'h2, 32'h0);
    bus(1'b1, `PMEC_OFF_IMR, 32'h0);
    @(posedge clk);
    check(irq, 1'b0);
    bus(1'b1, `PMEC_OFF_CTL, 32'h1);
    fire(8'h40, 7'h20);
    rdx(`PMEC_OFF_CSR, 32'h0);
    $display("access test done");
    init_port();
    bus(1'b1, `PMEC_OFF_CSR, 32'h80);
    @(posedge clk);
    check(seq_halt, 1'b1);
    check(bp_inh, 1'b0);
    fire(8'h40, '0);
    rdx(`PMEC_OFF_CSR, 32'h80);
    pwr <= 1'b1;
    bus(1'b1, `PMEC_OFF_CSR, 32'h0);
    @(posedge clk);
    check(seq_halt, 1'b1);
    pwr <= 1'b0;
    @(posedge clk);
    check(seq_halt, 1'b0);
    bus(1'b1, `PMEC_OFF_CSR, 32'h80);
    bus(1'b1, `PMEC_OFF_CSR, 32'h0);
    @(posedge clk);
    check(seq_halt, 1'b0);
    bus(1'b1, `PMEC_OFF_CTL, 32'h1);
    pulse(2);
    check(bp_inh, 1'b1);
    check(seq_halt, 1'b1);
    rdx(`PMEC_OFF_CSR, 32'h80);
    $display("halt test done");
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule : testbench

`default_nettype wire
